// file: core/sek_pkg.sv
// Constants and types shared by the serial word memory port.
// Contract
// RL1: Sample serial input on clock rise, select high.
// RL2: Read bits change on serial clock rise.
// RL3: After programming, reselect shows ready/busy status.
// RL4: Output floats while chip select low.
// RL5: Controller deselects after every finished command.
// RL6: Programming self-timed, done within 5 ms.
// RL7: Array is 256 words of 16 bits.
// RL8: Continued read clocks stream following words.
// RL9: Power-up inhibits programming until enabled.
// RL10: Inhibit command blocks programming, reads still work.
// RL11: Array starts with every word all ones.
// RL12: Controller keeps serial clock at most 3 MHz.
// RL13: Zeros ignored; first one is start bit.
// RL14: Two-bit opcode then eight address bits, MSB first.
// RL15: Read sends zero dummy bit, then word MSB first.
// RL16: Write enable holds until inhibited again.
// RL17: Busy low, ready high; no command while busy.
// RL18: Erase gives all ones; writes self-erase first.
package sek_pkg;
  localparam int SEK_ADDR_W = 8;
  localparam int SEK_DATA_W = 16;
  localparam int SEK_WORDS = 256;
  localparam logic [15:0] SEK_ERASED = 16'hFFFF;
  localparam int SEK_CLK_HZ = 10_000_000;
  localparam int SEK_PROG_MS = 5;
  localparam int SEK_PROG_CYC = SEK_CLK_HZ / 1000 * SEK_PROG_MS;
  localparam logic [1:0] SEK_OP_EXT = 2'b00;
  localparam logic [1:0] SEK_OP_WRITE = 2'b01;
  localparam logic [1:0] SEK_OP_READ = 2'b10;
  localparam logic [1:0] SEK_OP_ERASE = 2'b11;
  localparam logic [1:0] SEK_EXT_ENABLE = 2'b11;
  localparam logic [1:0] SEK_EXT_INHIBIT = 2'b00;
  localparam logic [1:0] SEK_EXT_FILL = 2'b01;
  localparam logic [1:0] SEK_EXT_CLEAR = 2'b10;
  localparam logic [4:0] SEK_HDR_BITS = 5'h0A;
  localparam logic [4:0] SEK_WORD_LAST = 5'h0F;
  // Sequencer states.
  typedef enum logic [2:0] {
    SEK_IDLE = 3'b000,
    SEK_HDR = 3'b001,
    SEK_DATA = 3'b010,
    SEK_READ = 3'b011,
    SEK_ARMED = 3'b100,
    SEK_DONE = 3'b101
  } sek_state_t;
endpackage

// file: core/sek_sync.sv
// Two-flop synchroniser for one pin.
`timescale 1ns/1ps
`default_nettype none
module sek_sync (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  // Both stages; only the second stage is seen outside.
  typedef struct packed {
    logic s1;
    logic s2;
  } sek_sync_t;
  sek_sync_t st_r;
  sek_sync_t st_nxt;

  // Shift the pin through both stages.
  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // Synchronous reset to low.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// file: core/sek_port.sv
// Serial port and self-timed array of the 256 x 16 word memory.
`timescale 1ns/1ps
`default_nettype none
module sek_port
  import sek_pkg::*;
#(
  parameter int PROG_CYC = SEK_PROG_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic chip_select_i,
  input wire logic serial_clock_in_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  output logic busy_o
);
  // Pins after synchronisation.
  logic cs_s;
  logic sk_s;
  logic di_s;

  // The sync costs two cycles of latency, which the slow serial clock easily absorbs.
  // Each pin passes two flip-flops before any logic looks at it.
  sek_sync u_cs (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .d_i(chip_select_i), .q_o(cs_s));
  sek_sync u_sk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .d_i(serial_clock_in_i), .q_o(sk_s));
  sek_sync u_di (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .d_i(serial_in_i), .q_o(di_s));

  // Every bit of control state in one record.
  typedef struct packed {
    sek_state_t state;
    logic sk_d;
    logic cs_d;
    logic [4:0] cnt;
    logic [1:0] op;
    logic [7:0] addr;
    logic [15:0] shreg;
    logic wen;
    logic do_q;
    logic oe_n;
    logic stat;
    logic busy;
    logic [31:0] timer;
    logic pend;
    logic pend_all;
    logic [7:0] pend_addr;
    logic [15:0] pend_data;
  } sek_ctl_t;

  // Registered state and the value it takes at the next edge.
  sek_ctl_t st_r;
  sek_ctl_t st_nxt;

  // Array storage, written only by the self-timed cycle.
  // It powers up erased; reset leaves it alone, as a real array keeps its contents.
  logic [15:0] mem_r [SEK_WORDS] = '{default: SEK_ERASED};  // RL11
  // The addressed word is looked up directly; its bits still leave through a flip-flop.
  logic [15:0] rd_word;
  logic sk_rise;
  logic cs_fall;
  logic prog_done;

  // Edges are found on synchronised copies only.
  assign sk_rise = sk_s && !st_r.sk_d && cs_s;  // RL1
  assign cs_fall = st_r.cs_d && !cs_s;
  assign prog_done = st_r.busy && (st_r.timer == 32'h0000_0001);
  assign rd_word = mem_r[st_r.addr];

  // Sequencer and output path.
  always_comb begin
    st_nxt = st_r;
    st_nxt.sk_d = sk_s;
    st_nxt.cs_d = cs_s;
    // Programming runs off the system clock, the serial clock is not needed.
    if (st_r.busy) begin
      st_nxt.timer = st_r.timer - 32'h0000_0001;  // RL6
      if (prog_done) begin
        st_nxt.busy = 1'b0;
        st_nxt.timer = '0;
      end
    end
    // The pending marker drops once the timer has run out and the word is stored.
    if (st_r.pend && !st_r.busy) begin
      st_nxt.pend = 1'b0;
    end
    // A deselect aborts any half-received command; only a fully armed one survives it.
    // This lets a controller cancel a mistyped write by dropping select early.
    if (!cs_s) begin
      // Deselect resets the sequencer and floats the output.
      st_nxt.state = SEK_IDLE;  // RL5
      st_nxt.oe_n = 1'b1;  // RL4
      st_nxt.cnt = '0;
      if (cs_fall && st_r.state == SEK_ARMED) begin
        // A finished programming command launches on deselect.
        st_nxt.busy = 1'b1;  // RL6
        st_nxt.timer = 32'(PROG_CYC);
        st_nxt.stat = 1'b1;
        st_nxt.pend = 1'b1;
        // Remember what the armed command will program.
        st_nxt.pend_all = (st_r.op == SEK_OP_EXT);
        st_nxt.pend_addr = st_r.addr;
        st_nxt.pend_data = st_r.shreg;
      end
    end else begin
      // Status shows ready/busy while selected until the next start bit.
      if (st_r.stat && st_r.state == SEK_IDLE) begin
        st_nxt.oe_n = 1'b0;  // RL3
        st_nxt.do_q = !st_r.busy;  // RL17
      end
      if (sk_rise) begin
        case (st_r.state)
          SEK_IDLE: begin
            // Zeros before the start bit are skipped.
            if (di_s && !st_r.busy) begin
              st_nxt.state = SEK_HDR;  // RL13
              st_nxt.stat = 1'b0;
              st_nxt.oe_n = 1'b1;
              st_nxt.cnt = '0;
            end
          end
          SEK_HDR: begin
            // Opcode then address, most significant bit first.
            st_nxt.cnt = st_r.cnt + 5'h01;  // RL14
            if (st_r.cnt < 5'h02) begin
              st_nxt.op = {st_r.op[0], di_s};
            end else begin
              st_nxt.addr = {st_r.addr[6:0], di_s};
            end
            if (st_r.cnt == SEK_HDR_BITS - 5'h01) begin
              st_nxt.cnt = '0;
              st_nxt.state = SEK_DONE;
              case (st_r.op)
                SEK_OP_READ: begin
                  // Dummy zero leaves with the last address bit.
                  st_nxt.state = SEK_READ;
                  st_nxt.oe_n = 1'b0;
                  st_nxt.do_q = 1'b0;  // RL15
                  st_nxt.cnt = SEK_WORD_LAST;
                end
                SEK_OP_WRITE: begin
                  st_nxt.state = SEK_DATA;
                end
                SEK_OP_ERASE: begin
                  // Without write enable the command is swallowed silently.
                  if (st_r.wen) begin
                    st_nxt.state = SEK_ARMED;  // RL9
                  end
                  st_nxt.shreg = SEK_ERASED;  // RL18
                end
                default: begin
                  case (st_r.addr[6:5])
                    SEK_EXT_ENABLE: st_nxt.wen = 1'b1;  // RL16
                    SEK_EXT_INHIBIT: st_nxt.wen = 1'b0;  // RL10
                    SEK_EXT_FILL: st_nxt.state = SEK_DATA;
                    default: begin
                      // Clear-all reuses the erased pattern as its fill data.
                      if (st_r.wen) begin
                        st_nxt.state = SEK_ARMED;
                      end
                      st_nxt.shreg = SEK_ERASED;  // RL18
                    end
                  endcase
                end
              endcase
            end
          end
          SEK_DATA: begin
            // Collect one whole 16-bit word.
            st_nxt.shreg = {st_r.shreg[14:0], di_s};  // RL7
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == SEK_WORD_LAST) begin
              st_nxt.state = st_r.wen ? SEK_ARMED : SEK_DONE;  // RL9
            end
          end
          SEK_READ: begin
            // Each rise moves out the next bit; words follow on.
            st_nxt.do_q = rd_word[st_r.cnt[3:0]];  // RL2
            st_nxt.cnt = st_r.cnt - 5'h01;
            if (st_r.cnt == 5'h00) begin
              st_nxt.cnt = SEK_WORD_LAST;
              st_nxt.addr = st_r.addr + 8'h01;  // RL8
            end
          end
          default: begin
            // Armed or finished: clocks are ignored until deselect.
          end
        endcase
      end
    end
  end

  // State register.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      // Only the output enable differs from all zeros; the idle state code is itself zero.
      st_r <= '0;
      st_r.state <= SEK_IDLE;
      st_r.oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // The array has no reset port, and a program cycle stores its word
  // when the self-timed cycle completes.
  // One write process per word keeps every element on a single driver;
  // fill and clear-all reach every word in the same cycle.
  generate
    for (genvar g = 0; g < SEK_WORDS; g++) begin : g_word
      always_ff @(posedge sys_clk_i) begin
        if (prog_done && st_r.pend && (st_r.pend_all || st_r.pend_addr == 8'(g))) begin
          mem_r[g] <= st_r.pend_data;  // RL18
        end
      end
    end
  endgenerate

  // Every output comes straight from the state register, so none can glitch.
  assign serial_out_o = st_r.do_q;
  assign serial_out_oe_n_o = st_r.oe_n;
  assign busy_o = st_r.busy;
endmodule
`default_nettype wire

// file: testbench/sek_port_props.sv
// Checker for the serial word memory port.
`timescale 1ns/1ps
`default_nettype none
module sek_port_props #(
  parameter int PROG_CYC = 50
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic chip_select_i,
  input wire logic serial_clock_in_i,
  input wire logic serial_in_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_n_o,
  input wire logic busy_o
);
  int busy_cnt_r; // Length of the running program cycle.
  int sk_age_r; // Clocks since the last serial clock rise.
  logic sk_d_r;
  // Helper counters; the pin rise is taken raw, so the bound allows for sync delay.
  always_ff @(posedge sys_clk_i) begin
    sk_d_r <= serial_clock_in_i;
    busy_cnt_r <= (busy_o && rst_n_i) ? busy_cnt_r + 1 : 0;
    sk_age_r <= (serial_clock_in_i && !sk_d_r) || !rst_n_i ? 0 : sk_age_r + 1;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_desel;
    !chip_select_i [*5];
  endsequence
  sequence s_busy_seen;
    busy_o && $past(busy_o) && !serial_out_oe_n_o;
  endsequence
  property p_oe_hiz;
    s_desel |-> serial_out_oe_n_o;
  endproperty
  a_oe_hiz: assert property (p_oe_hiz) else $error("output driven while deselected");
  property p_oe_src;
    $fell(serial_out_oe_n_o) |-> $past(chip_select_i) && $past(chip_select_i, 2);
  endproperty
  a_oe_src: assert property (p_oe_src) else $error("output enabled without select");
  property p_busy_max;
    busy_cnt_r <= PROG_CYC;
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("program cycle too long");
  property p_busy_start;
    $rose(busy_o) |-> !chip_select_i;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("program began while selected");
  property p_busy_show;
    s_busy_seen |-> !serial_out_o;
  endproperty
  a_busy_show: assert property (p_busy_show) else $error("busy not shown low");
  property p_ready_show;
    $fell(busy_o) && !serial_out_oe_n_o |-> ##[0:2] serial_out_o;
  endproperty
  a_ready_show: assert property (p_ready_show) else $error("ready not shown high");
  property p_out_step;
    $changed(serial_out_o) && $stable(serial_out_oe_n_o) && !serial_out_oe_n_o && !busy_o && !$past(busy_o)
      && !$past(busy_o, 2) |-> sk_age_r <= 8;
  endproperty
  a_out_step: assert property (p_out_step) else $error("output moved without clock rise");
  property p_reset_idle;
    $rose(rst_n_i) |-> !busy_o [*3];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("busy after reset");
endmodule
bind sek_port sek_port_props #(.PROG_CYC(PROG_CYC)) u_props (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .chip_select_i(chip_select_i), .serial_clock_in_i(serial_clock_in_i), .serial_in_i(serial_in_i),
  .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o), .busy_o(busy_o));
`default_nettype wire

// file: testbench/sek_host.sv
// Controller model driving the memory's three input pins.
`timescale 1ns/1ps
`default_nettype none
module sek_host (
  input wire logic sys_clk_i,
  input wire logic serial_out_i,
  output logic chip_select_o,
  output logic serial_clock_o,
  output logic serial_in_o
);
  logic [63:0] rx; // Output level seen before each serial clock rise.
  initial begin
    chip_select_o = 0;
    serial_clock_o = 0;
    serial_in_o = 0;
    rx = 64'h0000_0000_0000_0000;
  end
  task automatic half();
    repeat (4) @(negedge sys_clk_i);
  endtask
  // Shifts n bits MSB first at 800 ns a bit; the clock idles low between frames.
  task automatic frame(input int n, input logic [63:0] v);
    chip_select_o = 1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_o = v[i];
      half();
      rx = {rx[62:0], serial_out_i};
      serial_clock_o = 1;
      half();
      serial_clock_o = 0;
    end
    half();
    rx = {rx[62:0], serial_out_i};
    chip_select_o = 0;
    serial_in_o = ~serial_in_o;
    half();
    half();
  endtask
  // Reselects and waits for ready, sending nothing while busy shows.
  task automatic poll(output logic first, output logic ok);
    chip_select_o = 1;
    half();
    first = serial_out_i;
    ok = 0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(negedge sys_clk_i);
      ok = (serial_out_i === 1'b1);
    end
    chip_select_o = 0;
    half();
    half();
  endtask
endmodule
`default_nettype wire

// file: testbench/sek_port_tb.sv
// Self-checking bench for the serial word memory port.
`timescale 1ns/1ps
`default_nettype none
module sek_port_tb;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  logic cs, sk, di, so, so_oe_n, busy;
  // Line level seen by the controller; a released line reads as the inverse of the last value.
  logic so_line;
  assign so_line = so_oe_n ? ~so : so;
  int fail_count = 0;
  int n_tests = 0;
  sek_host u_host (.sys_clk_i(sys_clk_i), .serial_out_i(so_line), .chip_select_o(cs), .serial_clock_o(sk),
    .serial_in_o(di));
  // A short program cycle keeps the run brief.
  sek_port #(.PROG_CYC(50)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .chip_select_i(cs),
    .serial_clock_in_i(sk), .serial_in_i(di), .serial_out_o(so), .serial_out_oe_n_o(so_oe_n), .busy_o(busy));
  initial forever #50 sys_clk_i = ~sys_clk_i;
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    u_host.frame(27, 64'({3'b110, a, 16'h0000}));
    check("read", u_host.rx[15:0], exp);
    check("dummy", {15'h0000, u_host.rx[16]}, 16'h0000);
  endtask
  // Programs, then expects busy on reselect and ready within the bound.
  task automatic pr(input int n, input logic [63:0] v);
    logic f, ok;
    u_host.frame(n, v);
    u_host.poll(f, ok);
    check("busy", {15'h0000, f}, 16'h0000);
    check("ready", {15'h0000, ok}, 16'h0001);
    if (!ok) give_verdict();
  endtask
  task automatic t_blocked(input logic [7:0] a);
    u_host.frame(27, 64'({3'b101, a, 16'h1234}));
    check("busy_o", {15'h0000, busy}, 16'h0000);
    rd(a, 16'hFFFF);
  endtask
  task automatic t_write();
    u_host.frame(11, 64'h0000_0000_0000_04C0);
    check("busy_o", {15'h0000, busy}, 16'h0000);
    pr(31, 64'({4'h0, 3'b101, 8'hFF, 16'hA5C3}));
    u_host.frame(43, 64'({3'b110, 8'hFF, 32'h0000_0000}));
    check("word", u_host.rx[31:16], 16'hA5C3);
    check("wrap", u_host.rx[15:0], 16'hFFFF);
  endtask
  task automatic t_bulk();
    pr(11, 64'h0000_0000_0000_07FF);
    rd(8'hFF, 16'hFFFF);
    pr(27, 64'({11'h440, 16'h0F0F}));
    rd(8'h07, 16'h0F0F);
    pr(11, 64'h0000_0000_0000_0480);
    rd(8'h07, 16'hFFFF);
    u_host.frame(11, 64'h0000_0000_0000_0400);
  endtask
  initial begin
    repeat (3) @(negedge sys_clk_i);
    rst_n_i = 1;
    repeat (3) @(negedge sys_clk_i);
    check("oe_n", {15'h0000, so_oe_n}, 16'h0001);
    t_blocked(8'h05);
    t_write();
    t_bulk();
    t_blocked(8'h07);
    give_verdict();
  end
endmodule
`default_nettype wire
